/* File: hw/sasc_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Host end: sends a word MSB first, then pulses latch enable
// Clock, data and latch enable all leave from core clock registers
module sasc_host
    import sasc_pkg::*;
(
    input  wire logic              core_clk,  // 200 MHz core clock
    input  wire logic              sys_rst,   // Synchronous reset, high
    input  wire logic              req,       // Start a transfer (pulse)
    input  wire logic [WORD_W-1:0] word,      // Word to send
    output var  logic              busy_q,    // Transfer in progress
    output var  logic              done_q,    // One-cycle completion pulse
    sasc_if.host                   link
);
    // One-hot sequencer states
    typedef enum logic [4:0] {
        SASC_IDLE  = 5'h01,  // Waiting for a request
        SASC_LOW   = 5'h02,  // Serial clock low, data settles
        SASC_HIGH  = 5'h04,  // Serial clock high, device samples
        SASC_SETUP = 5'h08,  // Gap before latch enable rises
        SASC_PULSE = 5'h10   // Latch enable held high
    } sasc_state_t;

    // Sequencer and link registers
    sasc_state_t       state_q;     // Sequencer state
    logic [WORD_W-1:0] shift_q;     // Outgoing word, bit now on the line in MSB
    logic [2:0]        bits_q;      // Bits left in the word
    logic [7:0]        cnt_q;       // Phase timer
    logic [7:0]        cnt_reload;  // Timer value for the next phase
    logic              sclk_q;      // Serial clock register
    logic              sdat_q;      // Serial data register
    logic              latch_q;     // Latch enable register
    logic              drive_q;     // Latch enable driven onto the pin
    // Decoded events
    logic              cnt_zero;    // Current phase has run out
    logic              take_req;    // Request accepted this cycle
    logic              bit_end;     // High phase over, clock falls
    logic              last_bit;    // Bit now ending closes the word
    logic              pulse_end;   // Latch enable pulse over

    // Link pins come straight from registers
    assign link.ser_clk         = sclk_q;
    assign link.ser_data        = sdat_q;
    assign link.latch_enable    = latch_q;
    assign link.latch_enable_oe = drive_q;

    // Phase timer has run out
    assign cnt_zero  = (cnt_q == 8'h00);
    // Requests only count while idle; busy ones are dropped
    assign take_req  = (state_q == SASC_IDLE) && req;
    // End of a high phase: clock falls and the next bit goes out
    assign bit_end   = (state_q == SASC_HIGH) && cnt_zero;
    // Fifth fall closes the word
    assign last_bit  = (bits_q == 3'h1);
    // End of the latch enable pulse
    assign pulse_end = (state_q == SASC_PULSE) && cnt_zero;

    // Timer load for the phase that follows; least times round up
    always_comb begin
        cnt_reload = 8'h00;  // Pulse end leaves timer at zero
        case (state_q)
            SASC_IDLE:  cnt_reload = 8'(CLK_HALF_CYC - 1);  // First low phase
            SASC_LOW:   cnt_reload = 8'(CLK_HALF_CYC - 1);  // High phase
            SASC_HIGH: begin
                if (last_bit) begin
                    cnt_reload = 8'(LAT_SETUP_CYC - 1);  // Gap after last fall
                end else begin
                    cnt_reload = 8'(CLK_HALF_CYC - 1);  // Next low phase
                end
            end
            SASC_SETUP: cnt_reload = 8'(LAT_PULSE_CYC - 1);  // Pulse width
            default:    cnt_reload = 8'h00;
        endcase
    end

    // Sequencer, one-hot
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= SASC_IDLE;
        end else begin
            case (state_q)
                SASC_IDLE: begin
                    // Start a word on request
                    if (req) begin
                        state_q <= SASC_LOW;
                    end
                end
                SASC_LOW: begin
                    // Data stable a half period before the rise
                    if (cnt_zero) begin
                        state_q <= SASC_HIGH;
                    end
                end
                SASC_HIGH: begin
                    // Five bits, then the latch enable gap
                    if (cnt_zero && last_bit) begin
                        state_q <= SASC_SETUP;
                    end else if (cnt_zero) begin
                        state_q <= SASC_LOW;
                    end
                end
                SASC_SETUP: begin
                    // Wait out the gap after the last fall
                    if (cnt_zero) begin
                        state_q <= SASC_PULSE;
                    end
                end
                SASC_PULSE: begin
                    // Hold the pulse for its least width
                    if (cnt_zero) begin
                        state_q <= SASC_IDLE;
                    end
                end
                default: state_q <= SASC_IDLE;  // Stray code recovers
            endcase
        end
    end

    // Phase timer: counts down, reloads as each phase ends
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_q <= 8'h00;
        end else if (take_req || (state_q != SASC_IDLE && cnt_zero)) begin
            cnt_q <= cnt_reload;  // New phase
        end else if (state_q != SASC_IDLE) begin
            cnt_q <= cnt_q - 8'h01;  // Phase running
        end
    end

    // Bits left in the word
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            bits_q <= 3'h0;
        end else if (take_req) begin
            bits_q <= 3'(WORD_W);  // Full word to go
        end else if (bit_end) begin
            bits_q <= bits_q - 3'h1;  // One bit out per fall
        end
    end

    // Outgoing word; moves one place per fall, MSB first
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            shift_q <= WORD_ZERO;
        end else if (take_req) begin
            shift_q <= word;  // Whole word captured at the start
        end else if (bit_end) begin
            shift_q <= {shift_q[WORD_W-2:0], 1'b0};  // Next bit into MSB
        end
    end

    // Serial data; changes only while the clock is low
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sdat_q <= 1'b0;
        end else if (take_req) begin
            sdat_q <= word[BIT_16DB];  // 16 dB bit goes first
        end else if (bit_end) begin
            sdat_q <= shift_q[BIT_16DB-1];  // Next bit after the fall
        end
    end

    // Serial clock, divided from the core clock
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sclk_q <= 1'b0;  // Idles low between words
        end else if (state_q == SASC_LOW && cnt_zero) begin
            sclk_q <= 1'b1;  // Rise after a full low phase
        end else if (bit_end) begin
            sclk_q <= 1'b0;  // Fall after a full high phase
        end
    end

    // Latch enable level: low while shifting, one pulse after the word
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            latch_q <= 1'b0;
        end else if (take_req) begin
            latch_q <= 1'b0;  // Held low while bits enter
        end else if (state_q == SASC_SETUP && cnt_zero) begin
            latch_q <= 1'b1;  // Rise after the gap
        end else if (pulse_end) begin
            latch_q <= 1'b0;  // Fall captures the word
        end
    end

    // Latch enable drive; pin is left to its pull-up until the first word
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            drive_q <= 1'b0;  // Released at power-up
        end else if (take_req) begin
            drive_q <= 1'b1;  // Driven from the first word on
        end
    end

    // Busy flag, from request to end of pulse
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
        end else if (take_req) begin
            busy_q <= 1'b1;  // Word accepted
        end else if (pulse_end) begin
            busy_q <= 1'b0;  // Word applied
        end
    end

    // Completion pulse, one cycle
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= pulse_end;  // Stands for one cycle only
        end
    end
endmodule
`default_nettype wire

/* File: shared/sasc_pkg.sv */
package sasc_pkg;
    // Word layout
    localparam int unsigned WORD_W   = 5;             // Attenuation word width
    localparam int unsigned BIT_16DB = 4;             // Position of 16 dB stage
    localparam int unsigned BIT_8DB  = 3;             // Position of 8 dB stage
    localparam int unsigned BIT_4DB  = 2;             // Position of 4 dB stage
    localparam int unsigned BIT_2DB  = 1;             // Position of 2 dB stage
    localparam int unsigned BIT_1DB  = 0;             // Position of 1 dB stage
    // Host core clock, ns
    localparam int unsigned CORE_PERIOD_NS = 5;       // 200 MHz
    // Link timing figures, ns
    localparam int unsigned CLK_HIGH_NS  = 30;        // Least serial clock high time
    localparam int unsigned CLK_LOW_NS   = 30;        // Least serial clock low time
    localparam int unsigned CLK_PER_NS   = 100;       // Period at 10 MHz ceiling
    localparam int unsigned LAT_SETUP_NS = 10;        // Last clock fall to enable rise
    localparam int unsigned LAT_PULSE_NS = 30;        // Least enable high time
    // Derived cycle counts, least times round up
    localparam int unsigned CLK_PER_CYC  = (CLK_PER_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int unsigned CLK_HALF_CYC = CLK_PER_CYC / 2;
    localparam int unsigned LAT_SETUP_CYC = (LAT_SETUP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int unsigned LAT_PULSE_CYC = (LAT_PULSE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam logic [WORD_W-1:0] WORD_ZERO = 5'h00; // Cleared word
endpackage

/* File: shared/sasc_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Three-wire link between host and attenuator
interface sasc_if;
    logic ser_clk;       // Serial clock, host driven
    logic ser_data;      // Serial data, host driven
    logic latch_enable;  // Latch enable, host driven
    logic latch_enable_oe;   // Host drives latch enable
    logic latch_enable_pin;  // Pin level seen by device, pull-up when undriven
    assign latch_enable_pin = latch_enable_oe ? latch_enable : 1'b1;
    modport host (output ser_clk, output ser_data, output latch_enable, output latch_enable_oe);
    modport dev  (input ser_clk, input ser_data, input latch_enable_pin);
endinterface
`default_nettype wire

/* File: hw/sasc_dev.sv */
`timescale 1ns/1ps
`default_nettype none
// Attenuator control end, clocked by the serial clock
module sasc_dev
    import sasc_pkg::*;
(
    input  wire logic              pwr_rst,     // Power-up load, high; loads shreg_q on ser_clk, forces the outputs at once
    input  wire logic [WORD_W-1:0] preset_pins, // Parallel power-up pins, 16 dB in MSB
    sasc_if.dev                    link,
    output var  logic              atten_ctrl_16db, // 16 dB stage
    output var  logic              atten_ctrl_8db,  // 8 dB stage
    output var  logic              atten_ctrl_4db,  // 4 dB stage
    output var  logic              atten_ctrl_2db,  // 2 dB stage
    output var  logic              atten_ctrl_1db   // 1 dB stage
);
    logic [WORD_W-1:0] shreg_q;  // Serial shift register
    logic [WORD_W-1:0] hold_q;   // Captured latch word
    logic [WORD_W-1:0] ctrl;     // Latch output
    logic              word_lsb; // Incoming bit

    assign word_lsb = link.ser_data;

    // Shift on every rising edge outside power-up load, whatever the enable
    always_ff @(posedge link.ser_clk) begin
        if (pwr_rst) begin
            shreg_q <= preset_pins;
        end else begin
            shreg_q <= {shreg_q[WORD_W-2:0], word_lsb};
        end
    end

    // Latch capture on falling enable; pin pulls high when undriven
    always_latch begin
        if (link.latch_enable_pin) begin
            hold_q = shreg_q;
        end
    end

    // Transparent while enable high, holds while low
    always_comb begin
        ctrl = link.latch_enable_pin ? shreg_q : hold_q;
        if (pwr_rst) begin
            ctrl = preset_pins;
        end
    end

    // Weighted stage drive, sum gives 0..31 dB
    assign atten_ctrl_16db = ctrl[BIT_16DB];
    assign atten_ctrl_8db  = ctrl[BIT_8DB];
    assign atten_ctrl_4db  = ctrl[BIT_4DB];
    assign atten_ctrl_2db  = ctrl[BIT_2DB];
    assign atten_ctrl_1db  = ctrl[BIT_1DB];
endmodule
`default_nettype wire

/* File: test/sasc_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// Host-side timing on the three-wire link, core clock domain
module sasc_sva (
    input wire logic core_clk,  // Core clock
    input wire logic sys_rst,   // Core reset, high
    input wire logic ser_clk,   // Serial clock
    input wire logic ser_data,  // Serial data
    input wire logic latch_pin  // Latch enable pin level
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [2:0] rises_q;        // Serial clock rises since enable fell
    // Count bits of the current word
    always_ff @(posedge core_clk) begin
        if (sys_rst || $fell(latch_pin)) rises_q <= 3'h0;
        else if ($rose(ser_clk)) rises_q <= rises_q + 3'h1;
    end
    clk_high_a: assert property ($rose(ser_clk) |-> ser_clk [*6])
        else $error("serial clock high phase too short");
    clk_low_a: assert property ($fell(ser_clk) |-> (!ser_clk) [*6])
        else $error("serial clock low phase too short");
    latch_pulse_a: assert property ($rose(latch_pin) |-> latch_pin [*6])
        else $error("latch enable pulse too short");
    latch_low_shift_a: assert property ($rose(ser_clk) |-> !latch_pin)
        else $error("latch enable high while shifting");
    latch_setup_a: assert property ($rose(latch_pin) |-> !$past(ser_clk) && !$past(ser_clk, 2))
        else $error("latch enable too soon after clock fall");
    data_setup_a: assert property ($rose(ser_clk) |-> ser_data == $past(ser_data, 2))
        else $error("serial data not set up before rise");
    data_hold_a: assert property (ser_clk && $past(ser_clk) |-> $stable(ser_data))
        else $error("serial data moved while clock high");
    latch_after_word_a: assert property ($rose(latch_pin) |-> rises_q == 3'h5)
        else $error("latch enable not after five bits");
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// Host and attenuator ends joined back to back
module testbench;
    import sasc_pkg::*;
    logic              core_clk, sys_rst, req, busy_q, done_q, pwr_rst;
    logic [WORD_W-1:0] word, preset_pins, atten;  // Atten is 16 dB in MSB
    logic [WORD_W-1:0] tbl [7] = '{5'h10, 5'h01, 5'h02, 5'h04, 5'h08, 5'h1F, 5'h00};
    int                mismatches, n_tests, i;
    sasc_if link ();
    sasc_host i_sasc_host (.core_clk, .sys_rst, .req, .word, .busy_q, .done_q, .link(link));
    sasc_dev i_sasc_dev (.pwr_rst, .preset_pins, .link(link),
        .atten_ctrl_16db(atten[4]), .atten_ctrl_8db(atten[3]), .atten_ctrl_4db(atten[2]),
        .atten_ctrl_2db(atten[1]), .atten_ctrl_1db(atten[0]));
    sasc_sva i_sasc_sva (.core_clk, .sys_rst, .ser_clk(link.ser_clk),
        .ser_data(link.ser_data), .latch_pin(link.latch_enable_pin));
    // Core clock, 5 ns
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // Compare one attenuation word
    task automatic chk(input string what, input logic [WORD_W-1:0] exp,
                       input logic [WORD_W-1:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Compare one single-bit flag
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // One-cycle start request
    task automatic start(input logic [WORD_W-1:0] w);
        @(posedge core_clk);
        #1 req = 1'b1;
        word = w;
        @(posedge core_clk);
        #1 req = 1'b0;
    endtask
    // Bounded wait for completion pulse
    task automatic wait_done();
        for (int n = 0; n < 300 && done_q !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        if (done_q !== 1'b1) begin
            mismatches++;
            summarize();
        end
    endtask
    // Bounded wait for the latch enable pulse
    task automatic wait_latch();
        for (int n = 0; n < 300 && link.latch_enable_pin !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        if (link.latch_enable_pin !== 1'b1) begin
            mismatches++;
            summarize();
        end
    endtask
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        req = 1'b0;
        word = 5'h00;
        pwr_rst = 1'b1;
        preset_pins = 5'h15;
        mismatches = 0;
        n_tests = 0;
        repeat (5) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        chk("power-up state", 5'h15, atten);
        chk_bit("undriven enable high", 1'b1, link.latch_enable_pin);
        start(5'h0A);
        wait_done();
        pwr_rst = 1'b0;
        chk("preset kept", 5'h15, atten);
        // Single-stage words, all stages, none; back to back
        for (i = 0; i < 7; i++) begin
            start(tbl[i]);
            wait_latch();
            chk("transparent latch", tbl[i], atten);
            wait_done();
            chk("applied word", tbl[i], atten);
        end
        // Hold during shifting, second request refused while busy
        start(5'h1B);
        repeat (60) @(posedge core_clk);
        #1;
        chk("held while shifting", 5'h00, atten);
        chk_bit("busy while shifting", 1'b1, busy_q);
        start(5'h04);
        wait_done();
        chk("word after refused request", 5'h1B, atten);
        repeat (150) @(posedge core_clk);
        #1;
        chk("refused request dropped", 5'h1B, atten);
        chk_bit("idle after word", 1'b0, busy_q);
        summarize();
    end
endmodule
`default_nettype wire
